/* File: hdl/status_queues_regs.svh */
`ifndef STATUS_QUEUES_REGS_SVH
`define STATUS_QUEUES_REGS_SVH

// Enable register reset values and widths
`define STD_EN_RESET      8'h00
`define WIDE_EN_RESET     16'h0000

// Error queue geometry and special entries
`define ERRQ_DEPTH        4'ha
`define ERRQ_LAST         4'h9
`define ERRQ_PTR_MAX      4'h9
`define ERRQ_PTR_ZERO     4'h0
`define CODE_OVERFLOW     16'sh015e
`define CODE_NONE         16'sh0000
`define TEXT_OVERFLOW     8'h01
`define TEXT_NONE         8'h00

// Output queue geometry
`define OUTQ_DEPTH        3'h4

// Code filter map window: codes -512 to +511
`define MAP_MIN           16'shfe00
`define MAP_MAX           16'sh01ff
`define MAP_BIAS          16'sh0200
`define MAP_FIRST         10'h000
`define MAP_LAST          10'h3ff

// Status codes, disabled at power-up
`define STATUS_LO         16'sh0064
`define STATUS_HI         16'sh00c7

`endif

/* File: hdl/status_pkg.sv */
package status_pkg;

  typedef logic signed [15:0] code_t;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_SET_STD_EN,
    OP_GET_STD_EN,
    OP_SET_OPER_EN,
    OP_GET_OPER_EN,
    OP_SET_MEAS_EN,
    OP_GET_MEAS_EN,
    OP_SET_QUES_EN,
    OP_GET_QUES_EN,
    OP_CLEAR_STATUS,
    OP_PRESET,
    OP_ERR_NEXT,
    OP_ERR_CLEAR,
    OP_FILT_EN_BEGIN,
    OP_FILT_EN_ITEM,
    OP_FILT_DIS_ITEM,
    OP_FILT_GET_EN,
    OP_FILT_GET_DIS
  } cmd_op_t;

  typedef enum logic [1:0] {
    FILL_DEFAULT,
    FILL_ZERO,
    FILL_ONE
  } fill_t;

endpackage

/* File: hdl/status_ram.sv */
`timescale 1ns/100ps
module status_ram #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 10,
  parameter int AW    = 4
) (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read; caller waits one edge after the address settles
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

endmodule

/* File: hdl/output_queue.sv */
`timescale 1ns/100ps
`include "status_queues_regs.svh"
module output_queue (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        push,
  input  wire logic [23:0] wdata,
  input  wire logic        pop,
  output logic      [23:0] rdata,
  output logic             full,
  output logic             empty
);

  logic [23:0] slot [4];
  logic [1:0]  head;
  logic [1:0]  tail;
  logic [2:0]  count;

  assign full  = (count == `OUTQ_DEPTH);
  assign empty = (count == 3'h0);

  always_ff @(posedge clk) begin
    if (push && !full) begin
      slot[tail] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      head  <= 2'h0;
      tail  <= 2'h0;
      count <= 3'h0;
      rdata <= 24'h000000;
    end else begin
      if (push && !full) begin
        tail <= tail + 2'h1;
      end
      if (pop && !empty) begin
        head  <= head + 2'h1;
        rdata <= slot[head];
      end
      count <= count + {2'h0, push && !full} - {2'h0, pop && !empty};
    end
  end

endmodule

/* File: hdl/status_queues.sv */
// Overview of operation
// [RULE1] Each summary output is the OR of event bits ANDed with enable bits.
// [RULE2] Standard event enable takes 0..255 from host and reads back.
// [RULE3] Operation, measurement, questionable enables take 0..65535 and read back.
// [RULE4] Writing 0 to an enable register clears all its bits.
// [RULE5] Power-up and preset clear enables; clear-status leaves them alone.
// [RULE6] Two FIFOs: output queue for responses, error queue for messages.
// [RULE7] A response leaves the output queue when read; cleared means empty.
// [RULE8] Message-available bit is set while the output queue holds data.
// [RULE9] Error-available bit is set while the error queue holds entries.
// [RULE10] Error queue holds ten entries.
// [RULE11] Error read returns oldest entry, code and text, then removes it.
// [RULE12] On filling, the last slot takes overflow entry code 350.
// [RULE13] Empty error read returns code 0; queue starts empty.
// [RULE14] Entry codes are signed: negative standard, positive maker-defined.
// [RULE15] Power-up enables error codes, disables status codes; clears keep filter.
// [RULE16] Enable list sets exactly the listed codes; disable list removes listed. Here listed codes outside -512..511 are ignored.
// [RULE17] Lists arrive as single codes or inclusive ranges, item by item.
// [RULE18] Enable with empty list blocks every message.
// [RULE19] Power-up and clear-status empty the error queue; preset does not.
// [RULE20] Error clear command empties the queue; enabled/disabled sets can be queried.
// [RULE21] Clear-status and power-up reset the event registers; preset does not.
// [RULE22] While overflow entry is held, new messages are dropped until a read.
// [RULE23] Disabled codes are dropped and do not touch error-available.
`timescale 1ns/100ps
`include "status_queues_regs.svh"
module status_queues (
  input  wire logic               CLOCK,
  input  wire logic               RST,
  input  wire logic               CMD_VALID,
  input  wire status_pkg::cmd_op_t CMD_OP,
  input  wire logic        [15:0] CMD_VALUE,
  input  wire status_pkg::code_t  CMD_CODE_A,
  input  wire status_pkg::code_t  CMD_CODE_B,
  output logic                    CMD_ACK,
  input  wire logic               MSG_VALID,
  input  wire status_pkg::code_t  MSG_CODE,
  input  wire logic        [7:0]  MSG_TEXT,
  output logic                    MSG_ACK,
  input  wire logic               INST_VALID,
  input  wire logic        [23:0] INST_DATA,
  output logic                    INST_ACK,
  input  wire logic               OUT_READ,
  output logic                    OUT_VALID,
  output logic             [23:0] OUT_DATA,
  input  wire logic        [7:0]  STD_EVENT,
  input  wire logic        [15:0] OPER_EVENT,
  input  wire logic        [15:0] MEAS_EVENT,
  input  wire logic        [15:0] QUES_EVENT,
  output logic                    ESB_SUMMARY,
  output logic                    OPER_SUMMARY,
  output logic                    MEAS_SUMMARY,
  output logic                    QUES_SUMMARY,
  output logic                    MAV,
  output logic                    EAV,
  output logic                    EVENT_CLEAR
);
  import status_pkg::*;

  typedef enum {
    S_IDLE,
    S_WALK,
    S_LOOK,
    S_DECIDE,
    S_QLOOK,
    S_QANS,
    S_EWAIT,
    S_EANS
  } state_t;

  state_t      state;
  logic [7:0]  std_en;
  logic [15:0] oper_en;
  logic [15:0] meas_en;
  logic [15:0] ques_en;

  logic [9:0]  walk_idx;
  logic [9:0]  walk_end;
  fill_t       walk_fill;
  code_t       walk_code;
  logic        map_wdata;
  logic        map_q;
  logic [9:0]  look_idx;
  logic        look_inwin;
  logic        look_default;
  logic        query_invert;
  // Codes outside the map keep their power-up default only until an enable list arrives
  logic        outside_on;

  code_t       msg_code;
  logic [7:0]  msg_text;
  logic [3:0]  err_head;
  logic [3:0]  err_tail;
  logic [3:0]  err_count;
  logic        err_accept;
  logic        err_pop;
  logic        err_clear;
  logic [23:0] err_wdata;
  logic [23:0] err_q;

  logic        oq_push;
  logic [23:0] oq_wdata;
  logic        oq_full;
  logic        oq_empty;
  logic        fsm_push;

  logic        take_msg;
  logic        take_cmd;
  logic        take_inst;
  code_t       range_lo;
  code_t       range_hi;
  logic        range_ok;

  function automatic logic in_window(input code_t c);
    return (c >= `MAP_MIN) && (c <= `MAP_MAX);
  endfunction

  function automatic logic [9:0] to_index(input code_t c);
    logic [15:0] s;
    s = c + `MAP_BIAS;
    return s[9:0];
  endfunction

  // Status codes start disabled, everything else enabled
  function automatic logic default_on(input code_t c);
    return !((c >= `STATUS_LO) && (c <= `STATUS_HI)); // see [RULE15]
  endfunction

  // Messages win over commands; at most one of the two taken per idle cycle, instrument data can be taken alongside a message
  assign take_msg = (state == S_IDLE) && MSG_VALID && !MSG_ACK;
  assign take_cmd = (state == S_IDLE) && !take_msg && CMD_VALID && !CMD_ACK && !oq_full;
  // Instrument data waits while a query answer is owed, so that answer always finds a free slot
  assign take_inst = INST_VALID && !INST_ACK && !oq_full && !fsm_push && !take_cmd
                     && !(state inside {S_QLOOK, S_QANS, S_EWAIT, S_EANS});

  // Range item: either order of the two codes, clipped to the map window
  always_comb begin
    range_lo = (CMD_CODE_A < CMD_CODE_B) ? CMD_CODE_A : CMD_CODE_B; // see [RULE17]
    range_hi = (CMD_CODE_A < CMD_CODE_B) ? CMD_CODE_B : CMD_CODE_A;
    range_ok = (range_hi >= `MAP_MIN) && (range_lo <= `MAP_MAX);
    if (range_lo < `MAP_MIN) begin
      range_lo = `MAP_MIN;
    end
    if (range_hi > `MAP_MAX) begin
      range_hi = `MAP_MAX;
    end
  end

  // Code filter map, one bit per code in the window
  assign walk_code = $signed({6'h00, walk_idx}) - `MAP_BIAS;

  always_comb begin
    case (walk_fill)
      FILL_DEFAULT: map_wdata = default_on(walk_code);
      FILL_ONE:     map_wdata = 1'b1;
      default:      map_wdata = 1'b0;
    endcase
  end

  status_ram #(.WIDTH(1), .DEPTH(1024), .AW(10)) filter_map (
    .clk   (CLOCK),
    .we    (state == S_WALK),
    .waddr (walk_idx),
    .wdata (map_wdata),
    .raddr (look_idx),
    .rdata (map_q)
  );

  // Main sequencer; starts by painting the power-up filter
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state        <= S_WALK;
      walk_idx     <= `MAP_FIRST;
      walk_end     <= `MAP_LAST;
      walk_fill    <= FILL_DEFAULT; // see [RULE15]
      look_idx     <= `MAP_FIRST;
      look_inwin   <= 1'b0;
      look_default <= 1'b0;
      query_invert <= 1'b0;
      outside_on   <= 1'b1;
      msg_code     <= `CODE_NONE;
      msg_text     <= `TEXT_NONE;
    end else begin
      case (state)
        S_IDLE: begin
          if (take_msg) begin
            look_idx     <= to_index(MSG_CODE);
            look_inwin   <= in_window(MSG_CODE);
            look_default <= default_on(MSG_CODE) && outside_on;
            msg_code     <= MSG_CODE; // see [RULE14]
            msg_text     <= MSG_TEXT;
            state        <= S_LOOK;
          end else if (take_cmd) begin
            case (CMD_OP)
              OP_ERR_NEXT: begin
                state <= S_EWAIT; // see [RULE11]
              end
              OP_FILT_EN_BEGIN: begin
                walk_idx  <= `MAP_FIRST; // see [RULE16]
                walk_end  <= `MAP_LAST;
                walk_fill <= FILL_ZERO; // see [RULE18]
                outside_on <= 1'b0; // see [RULE16] [RULE18]
                state     <= S_WALK;
              end
              OP_FILT_EN_ITEM, OP_FILT_DIS_ITEM: begin
                walk_idx  <= to_index(range_lo);
                walk_end  <= to_index(range_hi);
                walk_fill <= (CMD_OP == OP_FILT_EN_ITEM) ? FILL_ONE : FILL_ZERO; // see [RULE16]
                if (range_ok) begin
                  state <= S_WALK;
                end
              end
              OP_FILT_GET_EN, OP_FILT_GET_DIS: begin
                look_idx     <= to_index(CMD_CODE_A); // see [RULE20]
                look_inwin   <= in_window(CMD_CODE_A);
                look_default <= default_on(CMD_CODE_A) && outside_on;
                query_invert <= (CMD_OP == OP_FILT_GET_DIS);
                state        <= S_QLOOK;
              end
              default: begin
                state <= S_IDLE;
              end
            endcase
          end
        end
        S_WALK: begin
          if (walk_idx == walk_end) begin
            state <= S_IDLE;
          end else begin
            walk_idx <= walk_idx + 10'h001;
          end
        end
        S_LOOK:   state <= S_DECIDE;
        S_DECIDE: state <= S_IDLE;
        S_QLOOK:  state <= S_QANS;
        S_QANS:   state <= S_IDLE;
        S_EWAIT:  state <= S_EANS;
        S_EANS:   state <= S_IDLE;
        default:  state <= S_IDLE;
      endcase
    end
  end

  // Handshake acknowledgements, one-cycle pulses
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CMD_ACK  <= 1'b0;
      MSG_ACK  <= 1'b0;
      INST_ACK <= 1'b0;
    end else begin
      CMD_ACK  <= take_cmd;
      MSG_ACK  <= take_msg;
      INST_ACK <= take_inst;
    end
  end

  // Enable registers; writing 0 simply stores all zeros
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      std_en  <= `STD_EN_RESET; // see [RULE5]
      oper_en <= `WIDE_EN_RESET;
      meas_en <= `WIDE_EN_RESET;
      ques_en <= `WIDE_EN_RESET;
    end else if (take_cmd) begin
      case (CMD_OP)
        OP_SET_STD_EN:  std_en  <= CMD_VALUE[7:0]; // see [RULE2] [RULE4]
        OP_SET_OPER_EN: oper_en <= CMD_VALUE; // see [RULE3] [RULE4]
        OP_SET_MEAS_EN: meas_en <= CMD_VALUE;
        OP_SET_QUES_EN: ques_en <= CMD_VALUE;
        OP_PRESET: begin
          std_en  <= `STD_EN_RESET; // see [RULE5]
          oper_en <= `WIDE_EN_RESET;
          meas_en <= `WIDE_EN_RESET;
          ques_en <= `WIDE_EN_RESET;
        end
        default: begin
          std_en <= std_en;
        end
      endcase
    end
  end

  // Summary bits toward the status byte
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ESB_SUMMARY  <= 1'b0;
      OPER_SUMMARY <= 1'b0;
      MEAS_SUMMARY <= 1'b0;
      QUES_SUMMARY <= 1'b0;
    end else begin
      ESB_SUMMARY  <= |(STD_EVENT & std_en); // see [RULE1]
      OPER_SUMMARY <= |(OPER_EVENT & oper_en);
      MEAS_SUMMARY <= |(MEAS_EVENT & meas_en);
      QUES_SUMMARY <= |(QUES_EVENT & ques_en);
    end
  end

  // Event registers live elsewhere; held clear through reset, pulsed on clear-status
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      EVENT_CLEAR <= 1'b1;
    end else begin
      EVENT_CLEAR <= take_cmd && (CMD_OP == OP_CLEAR_STATUS); // see [RULE21]
    end
  end

  // Error queue admission: filter, then overflow handling
  assign err_accept = (state == S_DECIDE) && (look_inwin ? map_q : look_default) // see [RULE23]
                      && (err_count != `ERRQ_DEPTH); // see [RULE22]
  assign err_wdata  = (err_count == `ERRQ_LAST) ? {`CODE_OVERFLOW, `TEXT_OVERFLOW} // see [RULE12]
                                                : {msg_code, msg_text};
  assign err_pop    = (state == S_EANS) && (err_count != 4'h0);
  assign err_clear  = take_cmd && ((CMD_OP == OP_CLEAR_STATUS) || (CMD_OP == OP_ERR_CLEAR)); // see [RULE19] [RULE20]

  status_ram #(.WIDTH(24), .DEPTH(10), .AW(4)) error_store (
    .clk   (CLOCK),
    .we    (err_accept),
    .waddr (err_tail),
    .wdata (err_wdata),
    .raddr (err_head),
    .rdata (err_q)
  );

  // Pointers wrap at ten; clears and reads never overlap an admission
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      err_head  <= `ERRQ_PTR_ZERO; // see [RULE13] [RULE19]
      err_tail  <= `ERRQ_PTR_ZERO;
      err_count <= 4'h0;
    end else if (err_clear) begin
      err_head  <= `ERRQ_PTR_ZERO;
      err_tail  <= `ERRQ_PTR_ZERO;
      err_count <= 4'h0;
    end else if (err_accept) begin
      err_tail  <= (err_tail == `ERRQ_PTR_MAX) ? `ERRQ_PTR_ZERO : err_tail + 4'h1; // see [RULE10]
      err_count <= err_count + 4'h1;
    end else if (err_pop) begin
      err_head  <= (err_head == `ERRQ_PTR_MAX) ? `ERRQ_PTR_ZERO : err_head + 4'h1; // see [RULE11]
      err_count <= err_count - 4'h1;
    end
  end

  // Output queue feed: answers to queries first, instrument data otherwise
  always_comb begin
    fsm_push = 1'b0;
    oq_wdata = 24'h000000;
    if (state == S_QANS) begin
      fsm_push = 1'b1;
      oq_wdata = {23'h000000, (look_inwin ? map_q : look_default) ^ query_invert}; // see [RULE20]
    end else if (state == S_EANS) begin
      fsm_push = 1'b1;
      oq_wdata = (err_count != 4'h0) ? err_q : {`CODE_NONE, `TEXT_NONE}; // see [RULE13]
    end else if (take_cmd) begin
      case (CMD_OP)
        OP_GET_STD_EN: begin
          fsm_push = 1'b1;
          oq_wdata = {16'h0000, std_en}; // see [RULE2]
        end
        OP_GET_OPER_EN: begin
          fsm_push = 1'b1;
          oq_wdata = {8'h00, oper_en}; // see [RULE3]
        end
        OP_GET_MEAS_EN: begin
          fsm_push = 1'b1;
          oq_wdata = {8'h00, meas_en};
        end
        OP_GET_QUES_EN: begin
          fsm_push = 1'b1;
          oq_wdata = {8'h00, ques_en};
        end
        default: begin
          fsm_push = 1'b0;
        end
      endcase
    end
    oq_push = fsm_push || take_inst;
    if (!fsm_push) begin
      oq_wdata = INST_DATA;
    end
  end

  output_queue responses (
    .clk   (CLOCK),
    .rst   (RST),
    .push  (oq_push), // see [RULE6]
    .wdata (oq_wdata),
    .pop   (OUT_READ), // see [RULE7]
    .rdata (OUT_DATA),
    .full  (oq_full),
    .empty (oq_empty)
  );

  // Availability bits follow the queue occupancy one edge later
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      OUT_VALID <= 1'b0;
      MAV       <= 1'b0;
      EAV       <= 1'b0;
    end else begin
      OUT_VALID <= OUT_READ && !oq_empty; // see [RULE7]
      MAV       <= !oq_empty; // see [RULE8]
      EAV       <= (err_count != 4'h0); // see [RULE9]
    end
  end

endmodule

/* File: verif/status_queues_checker.sv */
`timescale 1ns/100ps
module status_queues_checker (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic        CMD_ACK,
  input wire logic        MSG_ACK,
  input wire logic        INST_ACK,
  input wire logic        OUT_READ,
  input wire logic        OUT_VALID,
  input wire logic [7:0]  STD_EVENT,
  input wire logic [15:0] OPER_EVENT,
  input wire logic        ESB_SUMMARY,
  input wire logic        OPER_SUMMARY,
  input wire logic        MAV,
  input wire logic        EAV,
  input wire logic        EVENT_CLEAR
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_read_req;
    OUT_READ && MAV && !$past(OUT_READ);
  endsequence
  sequence s_msg_pulse;
    MSG_ACK ##1 !MSG_ACK;
  endsequence

  property p_pop;
    s_read_req |=> OUT_VALID;
  endproperty
  a_pop: assert property (p_pop) else $error("queued word not delivered");
  property p_word_cause;
    OUT_VALID |-> $past(OUT_READ);
  endproperty
  a_word_cause: assert property (p_word_cause) else $error("word without a read");
  property p_cmd_ack;
    CMD_ACK |=> !CMD_ACK;
  endproperty
  a_cmd_ack: assert property (p_cmd_ack) else $error("command ack longer than one cycle");
  property p_msg_ack;
    MSG_ACK |-> s_msg_pulse;
  endproperty
  a_msg_ack: assert property (p_msg_ack) else $error("message ack longer than one cycle");
  property p_esb_off;
    (STD_EVENT == 8'h00) |=> !ESB_SUMMARY;
  endproperty
  a_esb_off: assert property (p_esb_off) else $error("standard summary without event");
  property p_oper_off;
    !(|OPER_EVENT) |=> !OPER_SUMMARY;
  endproperty
  a_oper_off: assert property (p_oper_off) else $error("operation summary without event");
  property p_eav_rise;
    $rose(EAV) |-> $past(MSG_ACK, 3);
  endproperty
  a_eav_rise: assert property (p_eav_rise) else $error("error flag rose without message");
  property p_mav_push;
    INST_ACK && !OUT_READ |=> MAV;
  endproperty
  a_mav_push: assert property (p_mav_push) else $error("message flag low after push");
  property p_clear_pulse;
    EVENT_CLEAR |=> !EVENT_CLEAR;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("event clear held too long");
endmodule

bind status_queues status_queues_checker status_queues_checker_inst (
  .CLOCK(CLOCK), .RST(RST), .CMD_ACK(CMD_ACK), .MSG_ACK(MSG_ACK), .INST_ACK(INST_ACK),
  .OUT_READ(OUT_READ), .OUT_VALID(OUT_VALID), .STD_EVENT(STD_EVENT), .OPER_EVENT(OPER_EVENT),
  .ESB_SUMMARY(ESB_SUMMARY), .OPER_SUMMARY(OPER_SUMMARY), .MAV(MAV), .EAV(EAV), .EVENT_CLEAR(EVENT_CLEAR)
);

/* File: verif/host_model.sv */
`timescale 1ns/100ps
module host_model (
  input  wire logic           clock,
  input  wire logic           cmd_ack,
  input  wire logic           mav,
  input  wire logic           out_valid,
  input  wire logic    [23:0] out_data,
  output logic                cmd_valid,
  output status_pkg::cmd_op_t cmd_op,
  output logic         [15:0] cmd_value,
  output status_pkg::code_t   code_a,
  output status_pkg::code_t   code_b,
  output logic                out_read
);
  import status_pkg::*;
  int pause = 0;
  initial begin
    cmd_valid = 1'b0;
    cmd_op = OP_NOP;
    cmd_value = 16'h0000;
    code_a = 16'sh0000;
    code_b = 16'sh0000;
    out_read = 1'b0;
  end
  task automatic send(input cmd_op_t op, input logic [15:0] v, input code_t a, input code_t b);
    repeat (pause) @(negedge clock);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_value = v;
    code_a = a;
    code_b = b;
    // No limit here: a filter paint can hold the bus off for a long time; the watchdog catches a hang
    while (cmd_ack !== 1'b1) begin
      @(negedge clock);
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    // Released lines must not look like a held value
    cmd_value = ~v;
    code_a = ~a;
    code_b = ~b;
  endtask
  task automatic fetch(output logic [23:0] d);
    int n = 0;
    while (mav !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    out_read = 1'b1;
    @(negedge clock);
    d = out_valid ? out_data : 24'hxxxxxx;
    out_read = 1'b0;
    // Let an edge pass so the read strobe drops and the message flag catches up
    @(negedge clock);
  endtask
endmodule

/* File: verif/test_status_queues.sv */
`timescale 1ns/100ps
module test_status_queues;
  import status_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid, cmd_ack, msg_valid, msg_ack, inst_valid, inst_ack, out_read, out_valid;
  logic        esb, oper_sum, meas_sum, ques_sum, mav, eav, event_clear;
  cmd_op_t     cmd_op;
  code_t       code_a, code_b, msg_code;
  logic [15:0] cmd_value, ev;
  logic [7:0]  msg_text;
  logic [23:0] inst_data, out_data, d;
  int          bad_count = 0;
  int          total_checks = 0;
  int          clr_seen = 0;
  cmd_op_t     wr_op [4] = '{OP_SET_STD_EN, OP_SET_OPER_EN, OP_SET_MEAS_EN, OP_SET_QUES_EN};
  cmd_op_t     rd_op [4] = '{OP_GET_STD_EN, OP_GET_OPER_EN, OP_GET_MEAS_EN, OP_GET_QUES_EN};
  logic [15:0] full [4] = '{16'h00ff, 16'hffff, 16'hffff, 16'hffff};
  logic [15:0] en [4] = '{16'h0020, 16'h0400, 16'h0020, 16'h8000};

  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    if (event_clear && !rst) begin
      clr_seen++;
    end
  end

  status_queues status_queues_inst (
    .CLOCK(clock), .RST(rst), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_VALUE(cmd_value),
    .CMD_CODE_A(code_a), .CMD_CODE_B(code_b), .CMD_ACK(cmd_ack), .MSG_VALID(msg_valid),
    .MSG_CODE(msg_code), .MSG_TEXT(msg_text), .MSG_ACK(msg_ack), .INST_VALID(inst_valid),
    .INST_DATA(inst_data), .INST_ACK(inst_ack), .OUT_READ(out_read), .OUT_VALID(out_valid),
    .OUT_DATA(out_data), .STD_EVENT(ev[7:0]), .OPER_EVENT(ev), .MEAS_EVENT(ev), .QUES_EVENT(ev),
    .ESB_SUMMARY(esb), .OPER_SUMMARY(oper_sum), .MEAS_SUMMARY(meas_sum), .QUES_SUMMARY(ques_sum),
    .MAV(mav), .EAV(eav), .EVENT_CLEAR(event_clear)
  );
  host_model host_model_inst (
    .clock(clock), .cmd_ack(cmd_ack), .mav(mav), .out_valid(out_valid), .out_data(out_data),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_value(cmd_value), .code_a(code_a), .code_b(code_b),
    .out_read(out_read)
  );

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input cmd_op_t op, input logic [15:0] v, input code_t a);
    host_model_inst.send(op, v, a, a);
  endtask
  task automatic get(input cmd_op_t op, input code_t a);
    cmd(op, 16'h0000, a);
    host_model_inst.fetch(d);
  endtask
  task automatic hs(input bit err);
    // No limit: a message must wait out a filter paint; the watchdog catches a hang
    while ((err ? msg_ack : inst_ack) !== 1'b1) begin
      @(negedge clock);
    end
    @(negedge clock);
  endtask
  task automatic post(input code_t c, input logic [7:0] t);
    @(negedge clock);
    msg_valid = 1'b1;
    msg_code = c;
    msg_text = t;
    hs(1'b1);
    msg_valid = 1'b0;
    msg_code = ~c;
    msg_text = ~t;
    repeat (4) @(negedge clock);
  endtask
  task automatic summ(input logic [15:0] e, input logic [3:0] exp);
    @(negedge clock);
    ev = e;
    repeat (3) @(negedge clock);
    chk("summary", {20'h00000, exp}, {20'h00000, esb, oper_sum, meas_sum, ques_sum});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    stop_test();
  end

  initial begin
    msg_valid = 1'b0;
    msg_code = 16'sh0000;
    msg_text = 8'h00;
    inst_valid = 1'b0;
    inst_data = 24'h000000;
    ev = 16'h0000;
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    // Filter paint takes 1024 cycles after release
    repeat (1040) @(negedge clock);
    for (int k = 0; k < 4; k++) begin
      get(rd_op[k], 16'sh0000);
      chk("enable reset", 24'h000000, d);
      cmd(wr_op[k], full[k], 16'sh0000);
      get(rd_op[k], 16'sh0000);
      chk("enable full", {8'h00, full[k]}, d);
      cmd(wr_op[k], en[k], 16'sh0000);
    end
    summ(16'h0020, 4'b1010);
    summ(16'h8400, 4'b0101);
    clr_seen = 0;
    cmd(OP_CLEAR_STATUS, 16'h0000, 16'sh0000);
    chk("event clear", 24'h000001, 24'(clr_seen));
    get(rd_op[1], 16'sh0000);
    chk("enable kept", {8'h00, en[1]}, d);
    summ(16'hffff, 4'b1111);
    cmd(wr_op[0], 16'h0000, 16'sh0000);
    summ(16'hffff, 4'b0111);
    cmd(OP_PRESET, 16'h0000, 16'sh0000);
    summ(16'hffff, 4'b0000);
    get(OP_ERR_NEXT, 16'sh0000);
    chk("empty entry", 24'h000000, d);
    for (int i = 0; i < 12; i++) post(code_t'(-100 - i), 8'(i));
    chk("eav set", 24'h000001, {23'h000000, eav});
    for (int i = 0; i < 10; i++) begin
      get(OP_ERR_NEXT, 16'sh0000);
      chk("entry", (i == 9) ? 24'h015e01 : {16'(-100 - i), 8'(i)}, d);
    end
    post(16'sh0096, 8'h07);
    chk("eav clear", 24'h000000, {23'h000000, eav});
    host_model_inst.pause = 2;
    cmd(OP_FILT_EN_BEGIN, 16'h0000, 16'sh0000);
    host_model_inst.send(OP_FILT_EN_ITEM, 16'h0000, -16'sd110, -16'sd222);
    cmd(OP_FILT_EN_ITEM, 16'h0000, -16'sd300);
    post(-16'sd150, 8'h01);
    post(-16'sd101, 8'h02);
    get(OP_FILT_GET_EN, -16'sd222);
    chk("listed on", 24'h000001, {23'h000000, d[0]});
    get(OP_FILT_GET_DIS, -16'sd101);
    chk("unlisted off", 24'h000001, {23'h000000, d[0]});
    cmd(OP_FILT_DIS_ITEM, 16'h0000, -16'sd150);
    get(OP_FILT_GET_EN, -16'sd150);
    chk("removed", 24'h000000, {23'h000000, d[0]});
    cmd(OP_PRESET, 16'h0000, 16'sh0000);
    get(OP_ERR_NEXT, 16'sh0000);
    chk("after preset", 24'hff6a01, d);
    post(-16'sd300, 8'h03);
    cmd(OP_CLEAR_STATUS, 16'h0000, 16'sh0000);
    get(OP_ERR_NEXT, 16'sh0000);
    chk("after clear", 24'h000000, d);
    post(-16'sd300, 8'h04);
    cmd(OP_ERR_CLEAR, 16'h0000, 16'sh0000);
    get(OP_ERR_NEXT, 16'sh0000);
    chk("after err clear", 24'h000000, d);
    post(-16'sd300, 8'h05);
    get(OP_ERR_NEXT, 16'sh0000);
    chk("filter kept", 24'hfed405, d);
    cmd(OP_FILT_EN_BEGIN, 16'h0000, 16'sh0000);
    post(-16'sd300, 8'h06);
    post(-16'sd600, 8'h08);
    chk("empty list", 24'h000000, {23'h000000, eav});
    host_model_inst.pause = 0;
    for (int i = 0; i < 3; i++) begin
      @(negedge clock);
      inst_valid = 1'b1;
      inst_data = 24'ha00000 + 24'(i);
      hs(1'b0);
      inst_valid = 1'b0;
      inst_data = ~inst_data;
    end
    repeat (2) @(negedge clock);
    chk("mav set", 24'h000001, {23'h000000, mav});
    for (int i = 0; i < 3; i++) begin
      host_model_inst.fetch(d);
      chk("response", 24'ha00000 + 24'(i), d);
    end
    repeat (3) @(negedge clock);
    chk("mav clear", 24'h000000, {23'h000000, mav});
    stop_test();
  end
endmodule
